// ==== rtl/tdmlb_regs.svh ====
// Purpose: Register offsets, field positions and timing figures of the
//          local bus port.
// Assumes: Every register is one aligned 32-bit word.
// Notes:   Definitions only.
`ifndef TDMLB_REGS_SVH
`define TDMLB_REGS_SVH
`define TDMLB_CTRL_OFS 8'h00
`define TDMLB_STAT_OFS 8'h04
`define TDMLB_IN_RATE_OFS 8'h08
`define TDMLB_OUT_RATE_OFS 8'h0c
`define TDMLB_OUT_SHIFT_OFS 8'h10
`define TDMLB_CONN_ADDR_OFS 8'h14
`define TDMLB_CONN_DATA_OFS 8'h18
`define TDMLB_IN_SHIFT_OFS 8'h40
`define TDMLB_CTRL_EN_BIT 0
`define TDMLB_CTRL_MASTER_BIT 1
`define TDMLB_CTRL_RATE_LSB 2
`define TDMLB_CTRL_RST 4'h0
`define TDMLB_STAT_LOST_BIT 16
`define TDMLB_CONN_VALID_BIT 12
`define TDMLB_HC_RST 12'hfff
`define TDMLB_FRAME_NS 64'd125000
`define TDMLB_BASE_HZ 64'd2048000
`define TDMLB_CLK_HZ 64'd125000000
`define TDMLB_NS_PER_S 64'd1000000000
`define TDMLB_SYNC_HALVES 12'h002
`define TDMLB_RESP_OKAY 2'b00
`define TDMLB_RESP_SLVERR 2'b10
`endif

// ==== rtl/tdmlb_pkg.sv ====
// Purpose: Types shared by the local bus port.
// Assumes: Sixteen input and sixteen output lines.
// Notes:   Constants live in tdmlb_regs.svh.
package tdmlb_pkg;
   typedef enum logic [1:0] {
      TDMLB_R2M = 2'b00,
      TDMLB_R4M = 2'b01,
      TDMLB_R8M = 2'b10,
      TDMLB_R16M = 2'b11
   } tdmlb_rate_e;
   typedef logic [15:0] tdmlb_lines_t;
   typedef logic [11:0] tdmlb_half_t;
endpackage

// ==== rtl/tdmlb_port.sv ====
// Purpose: TDM local bus port with sixteen serial inputs and outputs,
//          a connection memory and an AXI4-Lite register slave.
// Assumes: All pins are synchronous to aclk; in slave mode the clock rate
//          field equals the rate of the received bit clock.
// Notes:   Contract
`timescale 1ns/1ns
`default_nettype none
`include "tdmlb_regs.svh"

module tdmlb_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Filling side.
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Draining side.
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign out_data = mem[rp_reg];
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_reg] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   a_fifo_count_up: assert property (@(posedge clk) disable iff (!rst_n)
      push && !pop |=> cnt_reg == $past(cnt_reg) + 1'b1)
      else $error("fifo count did not rise on push");
   a_fifo_never_over: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_reg == (AW+1)'(DEPTH) |=> cnt_reg <= (AW+1)'(DEPTH))
      else $error("fifo count passed its depth");
endmodule

module tdmlb_port #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Bit clock and frame sync pins.
   input wire logic bus_bit_clock_in,
   output logic bus_bit_clock_out,
   output logic bus_bit_clock_oe,
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe,
   // Serial data lines.
   input wire tdmlb_pkg::tdmlb_lines_t line_in,
   output tdmlb_pkg::tdmlb_lines_t line_out,
   output tdmlb_pkg::tdmlb_lines_t line_oe
);
   import tdmlb_pkg::*;
   localparam logic [12:0] HALF_BASE = 13'(64'd2 * `TDMLB_BASE_HZ *
      `TDMLB_FRAME_NS / `TDMLB_NS_PER_S);

   function automatic logic [1:0] kshift(input logic [1:0] cr,
      input logic [1:0] r);
      kshift = (cr > r) ? cr - r : 2'd0;
   endfunction
   function automatic logic [11:0] fmask(input logic [1:0] r);
      logic [12:0] t;
      t = HALF_BASE << r;
      fmask = 12'(t - 13'd1);
   endfunction
   function automatic logic [11:0] lmask(input logic [1:0] k);
      lmask = 12'((13'd1 << k) - 13'd1);
   endfunction
   function automatic logic [31:0] nco_inc(input logic [1:0] cr);
      logic [63:0] f;
      f = (64'd2 * `TDMLB_BASE_HZ) << cr;
      nco_inc = 32'((f << 32) / `TDMLB_CLK_HZ);
   endfunction
   function automatic logic [3:0] first_set(input logic [15:0] v);
      first_set = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            first_set = 4'(i);
         end
      end
   endfunction
   function automatic logic is_shift(input logic [7:0] a);
      is_shift = a[7:6] == `TDMLB_IN_SHIFT_OFS >> 6 && a[1:0] == 2'b00;
   endfunction
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = is_shift(a) || a == `TDMLB_CTRL_OFS ||
         a == `TDMLB_STAT_OFS || a == `TDMLB_IN_RATE_OFS ||
         a == `TDMLB_OUT_RATE_OFS || a == `TDMLB_OUT_SHIFT_OFS ||
         a == `TDMLB_CONN_ADDR_OFS || a == `TDMLB_CONN_DATA_OFS;
   endfunction
   function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         old[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
      end
      wmerge = old;
   endfunction

   // Software state.
   logic [3:0] ctrl_reg;
   logic [31:0] in_rate_reg;
   logic [31:0] out_rate_reg;
   logic [3:0] oshift_reg;
   logic [4:0] ishift_reg [16];
   logic [11:0] conn_addr_reg;
   logic [15:0] frame_cnt_reg;
   logic lost_reg;
   logic [12:0] clr_cnt_reg;
   logic [12:0] conn_mem [4096];
   logic [7:0] data_mem [4096];
   wire en = ctrl_reg[`TDMLB_CTRL_EN_BIT];
   wire master = ctrl_reg[`TDMLB_CTRL_MASTER_BIT];
   wire [1:0] clk_rate = ctrl_reg[`TDMLB_CTRL_RATE_LSB +: 2];
   wire clr_busy = !clr_cnt_reg[12];

   // AXI4-Lite slave; address and data are taken in either order.
   logic aw_have_reg, w_have_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire aw_have_next = (aw_have_reg || aw_hs) && !do_wr;
   wire w_have_next = (w_have_reg || w_hs) && !do_wr;
   wire wr_ok = reg_hit(waddr_reg);
   wire wr_ctrl = do_wr && waddr_reg == `TDMLB_CTRL_OFS;
   wire wr_stat = do_wr && waddr_reg == `TDMLB_STAT_OFS;
   wire wr_irate = do_wr && waddr_reg == `TDMLB_IN_RATE_OFS;
   wire wr_orate = do_wr && waddr_reg == `TDMLB_OUT_RATE_OFS;
   wire wr_oshift = do_wr && waddr_reg == `TDMLB_OUT_SHIFT_OFS;
   wire wr_caddr = do_wr && waddr_reg == `TDMLB_CONN_ADDR_OFS;
   wire wr_cdata = do_wr && waddr_reg == `TDMLB_CONN_DATA_OFS && !clr_busy;
   wire wr_ishift = do_wr && is_shift(waddr_reg);
   wire [31:0] wm_ctrl = wmerge({28'h0, ctrl_reg}, wdata_reg, wstrb_reg);
   wire [31:0] wm_irate = wmerge(in_rate_reg, wdata_reg, wstrb_reg);
   wire [31:0] wm_orate = wmerge(out_rate_reg, wdata_reg, wstrb_reg);
   wire [31:0] wm_caddr = wmerge({20'h0, conn_addr_reg}, wdata_reg,
      wstrb_reg);
   wire [31:0] wm_cdata = wmerge({19'h0, conn_mem[conn_addr_reg]},
      wdata_reg, wstrb_reg);
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case (s_axi_araddr)
         `TDMLB_CTRL_OFS: rd_mux = {28'h0, ctrl_reg};
         `TDMLB_STAT_OFS: rd_mux = {14'h0, clr_busy, lost_reg,
            frame_cnt_reg};
         `TDMLB_IN_RATE_OFS: rd_mux = in_rate_reg;
         `TDMLB_OUT_RATE_OFS: rd_mux = out_rate_reg;
         `TDMLB_OUT_SHIFT_OFS: rd_mux = {28'h0, oshift_reg};
         `TDMLB_CONN_ADDR_OFS: rd_mux = {20'h0, conn_addr_reg};
         `TDMLB_CONN_DATA_OFS: rd_mux = {19'h0, conn_mem[conn_addr_reg]};
         default: begin
            if (is_shift(s_axi_araddr)) begin
               rd_mux = {27'h0, ishift_reg[s_axi_araddr[5:2]]};
            end
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TDMLB_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `TDMLB_RESP_OKAY;
         waddr_reg <= 8'h0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         s_axi_awready <= !aw_have_next;
         s_axi_wready <= !w_have_next;
         if (aw_hs) begin
            waddr_reg <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `TDMLB_RESP_OKAY : `TDMLB_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !(ar_hs || (s_axi_rvalid && !s_axi_rready));
         if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= reg_hit(s_axi_araddr) ? `TDMLB_RESP_OKAY :
               `TDMLB_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Bit clock timing: one tick per half period of the bus bit clock.
   logic clk_q_reg, fs_q_reg, fs_pend_reg, tick_d_reg;
   logic bclk_out_reg;
   logic [31:0] nco_reg;
   logic [11:0] hc_reg;
   wire [32:0] nco_sum = {1'b0, nco_reg} + {1'b0, nco_inc(clk_rate)};
   wire tick = master ? nco_sum[32] : (bus_bit_clock_in ^ clk_q_reg);
   wire rise = master ? !bclk_out_reg : bus_bit_clock_in;
   wire level = master ? bclk_out_reg : clk_q_reg;
   wire [11:0] fmax = fmask(clk_rate);
   wire wrap = hc_reg >= fmax;
   wire fs_rise = !master && frame_sync_in && !fs_q_reg;
   wire frame_start = tick && rise && (fs_pend_reg || wrap);
   wire [11:0] hc_next = frame_start ? 12'h0 :
      (tick ? (wrap ? 12'h0 : hc_reg + 12'h1) : hc_reg);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_q_reg <= 1'b0;
         fs_q_reg <= 1'b0;
         fs_pend_reg <= 1'b0;
         tick_d_reg <= 1'b0;
         nco_reg <= 32'h0;
         hc_reg <= `TDMLB_HC_RST;
         frame_cnt_reg <= 16'h0;
         bclk_out_reg <= 1'b0;
         bus_bit_clock_out <= 1'b0;
         bus_bit_clock_oe <= 1'b0;
         frame_sync_out <= 1'b0;
         frame_sync_oe <= 1'b0;
      end else begin
         clk_q_reg <= bus_bit_clock_in;
         fs_q_reg <= frame_sync_in;
         fs_pend_reg <= fs_rise || (fs_pend_reg && !frame_start);
         tick_d_reg <= tick;
         nco_reg <= master ? nco_sum[31:0] : 32'h0;
         hc_reg <= hc_next;
         if (frame_start) begin
            frame_cnt_reg <= frame_cnt_reg + 16'h1;
         end
         if (master && tick) begin
            bclk_out_reg <= !bclk_out_reg;
         end
         bus_bit_clock_out <= master && (tick ? !bclk_out_reg :
            bclk_out_reg);
         bus_bit_clock_oe <= master;
         frame_sync_out <= master && hc_next < `TDMLB_SYNC_HALVES;
         frame_sync_oe <= master;
      end
   end

   // Line datapath: per-line position in half bits of the line's own rate.
   logic [15:0] rdy_reg;
   logic [15:0] lost_set;
   logic [7:0] isr_reg [16];
   logic [7:0] rx_byte_reg [16];
   logic [7:0] rx_slot_reg [16];
   logic [15:0] samp_w;
   logic [15:0] start_w;
   logic [11:0] po_w [16];
   logic [15:0] pf_full_reg, pf_vld_reg, oconn_reg;
   logic [7:0] pf_byte_reg [16];
   logic [7:0] obyte_reg [16];
   logic [3:0] scan_reg;
   wire [3:0] sel = first_set(rdy_reg);
   wire fifo_in_ready;
   wire push = (|rdy_reg) && fifo_in_ready;
   wire [11:0] scan_mask = fmask(out_rate_reg[{scan_reg, 1'b0} +: 2]);
   wire [7:0] nslot = (po_w[scan_reg][11:4] + 8'h1) & scan_mask[11:4];
   wire [12:0] cm_rd = conn_mem[{scan_reg, nslot}];
   wire [7:0] dm_rd = data_mem[cm_rd[11:0]];
   wire pf_load = !pf_full_reg[scan_reg] && !start_w[scan_reg] && !clr_busy;

   genvar gi;
   for (gi = 0; gi < 16; gi++) begin : g_line
      wire [1:0] ir = in_rate_reg[2*gi +: 2];
      wire [1:0] ki = kshift(clk_rate, ir);
      wire [11:0] pi = 12'((hc_reg >> ki) -
         {{7{ishift_reg[gi][4]}}, ishift_reg[gi]}) & fmask(ir);
      wire evi = tick_d_reg && (hc_reg & lmask(ki)) == 12'h0;
      wire done = samp_w[gi] && pi[3:1] == 3'h7;
      wire [1:0] ro = out_rate_reg[2*gi +: 2];
      wire [1:0] ko = kshift(clk_rate, ro);
      wire [11:0] po = 12'((hc_reg >> ko) - {8'h0, oshift_reg}) &
         fmask(ro);
      wire drv = tick_d_reg && (hc_reg & lmask(ko)) == 12'h0 && !po[0];
      assign samp_w[gi] = evi && pi[0] && en;
      assign start_w[gi] = drv && po[3:0] == 4'h0;
      assign po_w[gi] = po;
      assign lost_set[gi] = done && rdy_reg[gi] && !(push && sel == gi);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            isr_reg[gi] <= 8'h0;
            rdy_reg[gi] <= 1'b0;
            rx_byte_reg[gi] <= 8'h0;
            rx_slot_reg[gi] <= 8'h0;
         end else begin
            if (samp_w[gi]) begin
               isr_reg[gi] <= {isr_reg[gi][6:0], line_in[gi]};
            end
            if (done) begin
               rdy_reg[gi] <= 1'b1;
               rx_byte_reg[gi] <= {isr_reg[gi][6:0], line_in[gi]};
               rx_slot_reg[gi] <= pi[11:4];
            end else if (push && sel == gi) begin
               rdy_reg[gi] <= 1'b0;
            end
         end
      end
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pf_full_reg[gi] <= 1'b0;
            pf_vld_reg[gi] <= 1'b0;
            pf_byte_reg[gi] <= 8'h0;
            oconn_reg[gi] <= 1'b0;
            obyte_reg[gi] <= 8'h0;
            line_out[gi] <= 1'b0;
            line_oe[gi] <= 1'b0;
         end else begin
            if (pf_load && scan_reg == gi) begin
               pf_full_reg[gi] <= 1'b1;
               pf_vld_reg[gi] <= cm_rd[`TDMLB_CONN_VALID_BIT];
               pf_byte_reg[gi] <= dm_rd;
            end else if (start_w[gi]) begin
               pf_full_reg[gi] <= 1'b0;
            end
            if (start_w[gi]) begin
               obyte_reg[gi] <= pf_byte_reg[gi];
               oconn_reg[gi] <= pf_full_reg[gi] && pf_vld_reg[gi];
               line_out[gi] <= pf_byte_reg[gi][7];
            end else if (drv) begin
               line_out[gi] <= obyte_reg[gi][~po[3:1]];
            end
            line_oe[gi] <= en && (start_w[gi] ? pf_full_reg[gi] &&
               pf_vld_reg[gi] : oconn_reg[gi]);
         end
      end
   end

   // Received bytes queue here; draining stalls while the prefetch owns
   // the memories.
   wire [19:0] fifo_out;
   wire fifo_out_valid;
   tdmlb_fifo #(.WIDTH(20), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(aclk),
      .rst_n(aresetn),
      .in_data({sel, rx_slot_reg[sel], rx_byte_reg[sel]}),
      .in_valid(|rdy_reg),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_out_valid),
      .out_ready(!pf_load)
   );
   always_ff @(posedge aclk) begin
      if (fifo_out_valid && !pf_load) begin
         data_mem[fifo_out[19:8]] <= fifo_out[7:0];
      end
      if (clr_busy) begin
         conn_mem[clr_cnt_reg[11:0]] <= 13'h0;
      end else if (wr_cdata) begin
         conn_mem[conn_addr_reg] <= wm_cdata[12:0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `TDMLB_CTRL_RST;
         in_rate_reg <= 32'h0;
         out_rate_reg <= 32'h0;
         oshift_reg <= 4'h0;
         ishift_reg <= '{default: 5'h0};
         conn_addr_reg <= 12'h0;
         lost_reg <= 1'b0;
         clr_cnt_reg <= 13'h0;
         scan_reg <= 4'h0;
      end else begin
         scan_reg <= scan_reg + 4'h1;
         if (clr_busy) begin
            clr_cnt_reg <= clr_cnt_reg + 13'h1;
         end
         if (wr_ctrl) begin
            ctrl_reg <= wm_ctrl[3:0];
         end
         if (wr_irate) begin
            in_rate_reg <= wm_irate;
         end
         if (wr_orate) begin
            out_rate_reg <= wm_orate;
         end
         if (wr_oshift && wstrb_reg[0]) begin
            oshift_reg <= wdata_reg[3:0];
         end
         if (wr_ishift && wstrb_reg[0]) begin
            ishift_reg[waddr_reg[5:2]] <= wdata_reg[4:0];
         end
         if (wr_caddr) begin
            conn_addr_reg <= wm_caddr[11:0];
         end
         lost_reg <= (|lost_set) || (lost_reg && !(wr_stat &&
            wstrb_reg[2] && wdata_reg[`TDMLB_STAT_LOST_BIT]));
      end
   end

   a_standby_all_hiz: assert property (
      @(posedge aclk) disable iff
      (!aresetn) !en |=> line_oe == 16'h0)
      else $error("line driven while in standby");
   a_slot_needs_conn: assert property (
      @(posedge aclk) disable iff
      (!aresetn) line_oe[0] |-> $past(en && (oconn_reg[0] ||
      (start_w[0] && pf_full_reg[0] && pf_vld_reg[0]))))
      else $error("line driven in an unconnected slot");
   a_frame_restart: assert property (
      @(posedge aclk) disable iff
      (!aresetn) frame_start |=> hc_reg == 12'h0 &&
      frame_cnt_reg == $past(frame_cnt_reg) + 16'h1)
      else $error("frame start did not restart the counters");
   a_half_count: assert property (
      @(posedge aclk) disable iff (!aresetn)
      tick && !frame_start && !wrap |=> hc_reg == $past(hc_reg) + 12'h1)
      else $error("half-bit counter missed a tick");
   a_slave_pins: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !master |=> !bus_bit_clock_oe && !frame_sync_oe)
      else $error("slave drove clock or sync");
   a_master_clock: assert property (
      @(posedge aclk) disable iff
      (!aresetn) master && $stable(master) && tick |=>
      bus_bit_clock_out != $past(bus_bit_clock_out))
      else $error("master clock did not toggle on tick");
   a_master_sync: assert property (
      @(posedge aclk) disable iff
      (!aresetn) master && frame_start |=> frame_sync_out &&
      frame_sync_oe && bus_bit_clock_out)
      else $error("master sync missing at frame start");
   a_in_falling: assert property (
      @(posedge aclk) disable iff (!aresetn)
      samp_w[0] && kshift(clk_rate, in_rate_reg[1:0]) == 2'd0 &&
      !ishift_reg[0][0] |-> !level)
      else $error("input sampled outside the low clock phase");
   a_drop_standby: assert property (
      @(posedge aclk) disable iff
      (!aresetn) !en && !rdy_reg[0] |=> !rdy_reg[0])
      else $error("byte captured while lines are disabled");
endmodule
`default_nettype wire

// ==== tb/tdmlb_far_end.sv ====
// Purpose: Far-end TDM device supplying bit clock, frame sync and data.
// Assumes: One bit period is BIT_CYC aclk cycles; 256 bits to a frame.
// Notes:   Line 0 carries ones, line 1 toggles every bit.
`timescale 1ns/1ns
`default_nettype none
module tdmlb_far_end #(
   parameter int BIT_CYC = 61
) (
   // Clock.
   input wire logic aclk,
   // Bus pins.
   output logic bit_clk,
   output logic fsync,
   output logic [15:0] data
);
   int cyc = 0;
   int bitn = 0;
   always_ff @(posedge aclk) begin
      cyc <= (cyc == BIT_CYC - 1) ? 0 : cyc + 1;
      if (cyc == BIT_CYC - 1) begin
         bitn <= (bitn == 255) ? 0 : bitn + 1;
      end
   end
   // The clock runs at the slowest rate, so only line rate 0 is legal.
   assign bit_clk = (cyc < BIT_CYC / 2);
   assign fsync = (bitn == 0);
   assign data = {14'h0, bitn[0], 1'b1};
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the local bus port.
// Assumes: Slave clocking at 2.048 MHz from the far-end model.
// Notes:   Register access uses AXI4-Lite tasks.
`timescale 1ns/1ns
`default_nettype none
`include "tdmlb_regs.svh"
module testbench;
   import tdmlb_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0;
   wire logic awready, wready, arready, bvalid, rvalid;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic bclk, fs, bclk_oe, fs_oe;
   tdmlb_lines_t lin, lout, loe;
   int failures = 0, samples_checked = 0, on, bad, oth;
   logic [1:0] r;
   logic [31:0] d;
   tdmlb_far_end tdmlb_far_end_i (.aclk(aclk), .bit_clk(bclk), .fsync(fs),
      .data(lin));
   tdmlb_port tdmlb_port_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .bus_bit_clock_in(bclk), .bus_bit_clock_out(),
      .bus_bit_clock_oe(bclk_oe),
      .frame_sync_in(fs), .frame_sync_out(), .frame_sync_oe(fs_oe),
      .line_in(lin), .line_out(lout), .line_oe(loe));
   initial begin
      forever #4 aclk = ~aclk;
   end
   task automatic stop_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         n++;
      end while (!bvalid && n < 200);
      bready <= 0;
      r = bresp;
      if (n >= 200) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         n++;
      end while (!rvalid && n < 200);
      rready <= 0;
      r = rresp;
      d = rdata;
      if (n >= 200) begin
         failures++;
         stop_test();
      end
   endtask
   // Watches line 0 for one frame: drive time, wrong data, other lines.
   task automatic mon;
      on = 0;
      bad = 0;
      oth = 0;
      repeat (15616) begin
         @(posedge aclk);
         if (loe[0] === 1'b1) on++;
         if (loe[0] === 1'b1 && lout[0] !== 1'b1) bad++;
         if (loe[15:1] !== 15'h0) oth++;
      end
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk("line_oe", 32'(loe), 0);
      rd(`TDMLB_CTRL_OFS); chk("ctrl", d, 0);
      rd(`TDMLB_IN_SHIFT_OFS); chk("in_shift", d, 0);
      rd(`TDMLB_OUT_SHIFT_OFS); chk("out_shift", d, 0);
      rd(8'h3c); chk("unmapped", 32'(r), 32'(`TDMLB_RESP_SLVERR));
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(`TDMLB_IN_RATE_OFS, i); rd(`TDMLB_IN_RATE_OFS);
         chk("in_rate", d, i);
      end
      wr(`TDMLB_OUT_RATE_OFS, 32'h4); rd(`TDMLB_IN_RATE_OFS);
      chk("in_rate kept", d, 3);
      wr(`TDMLB_IN_RATE_OFS, 0); wr(`TDMLB_OUT_RATE_OFS, 0);
      $display("test rates done");
      repeat (4200) @(posedge aclk);
      rd(`TDMLB_STAT_OFS); chk("clear busy", 32'(d[17]), 0);
      wr(`TDMLB_CTRL_OFS, 1); mon();
      chk("oe unconnected", 32'(on + oth), 0);
      wr(`TDMLB_CONN_ADDR_OFS, 32'h001); wr(`TDMLB_CONN_DATA_OFS, 32'h1001);
      rd(`TDMLB_CONN_DATA_OFS); chk("conn", d, 32'h1001);
      mon(); mon();
      chk("slot bits", 32'(on >= 480 && on <= 500), 1);
      chk("slot data", 32'(bad), 0);
      chk("other oe", 32'(oth), 0);
      $display("test connection done");
      wr(`TDMLB_CTRL_OFS, 0); repeat (4) @(posedge aclk); mon();
      chk("standby oe", 32'(on + oth), 0);
      wr(`TDMLB_CTRL_OFS, 2); repeat (4) @(posedge aclk);
      chk("master oe", {30'h0, bclk_oe, fs_oe}, 3);
      wr(`TDMLB_CTRL_OFS, 0); repeat (4) @(posedge aclk);
      chk("slave oe", {30'h0, bclk_oe, fs_oe}, 0);
      $display("test standby done");
      stop_test();
   end
endmodule
`default_nettype wire
